//--- psq_sequencer.sv
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module psq_sequencer #(
  parameter int unsigned SHORT_CHECK_CYC = psq_pkg::T_SHORT_CHECK_MS * psq_pkg::CYC_PER_MS,
  parameter int unsigned CAP_CHECK_CYC = psq_pkg::T_CAP_CHECK_MS * psq_pkg::CYC_PER_MS,
  parameter int unsigned OC_FILTER_CYC = psq_pkg::T_OC_FILTER_US * psq_pkg::CYC_PER_US
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  // register bus
  input wire psq_pkg::psq_wb_req_t I_WB,
  output psq_pkg::psq_wb_rsp_t O_WB,
  // front panel buttons, rotary switch and limit source strap
  input wire logic I_BTN_ON,
  input wire logic I_BTN_OFF,
  input wire logic [3:0] I_ROTARY,
  input wire logic I_LIMIT_SOURCE_SELECT,
  // comparators
  input wire logic I_VOUT_ABOVE_10PCT,
  input wire logic I_VOUT_ABOVE_85PCT,
  input wire logic I_OVER_LIMIT,
  input wire logic I_OVER_160A,
  // power stage
  output logic O_PRECHARGE_SWITCH,
  output logic O_GATE_ON,
  output logic O_MAIN_PATH_ON,
  output logic [6:0] O_LIMIT_AMPS,
  // indicators
  output logic O_READY_INDICATOR,
  output logic O_PRECHARGE_INDICATOR,
  output logic O_ON_INDICATOR,
  output logic O_SHORT_INDICATOR,
  output logic O_CAPACITANCE_FAULT_INDICATOR,
  output logic O_OVERCURRENT_INDICATOR
);
  import psq_pkg::*;

  // ----------------------------------------------------------
  // derived counts
  // ----------------------------------------------------------
  localparam int unsigned GATE_SETTLE_CYC = T_GATE_SETTLE_US * CYC_PER_US;
  localparam logic [TIMER_W-1:0] SHORT_AT = TIMER_W'(SHORT_CHECK_CYC - 1);
  localparam logic [TIMER_W-1:0] CAP_AT = TIMER_W'(CAP_CHECK_CYC - 1);
  localparam logic [TIMER_W-1:0] SETTLE_AT = TIMER_W'(GATE_SETTLE_CYC - 1);
  localparam logic [OC_W-1:0] OC_AT = OC_W'(OC_FILTER_CYC);

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  typedef struct packed {
    psq_state_t state;
    logic [TIMER_W-1:0] timer;
    logic [OC_W-1:0] oc_cnt;
    psq_faults_t faults;
    logic on_prev;
    logic off_prev;
    logic ready;
    logic [6:0] ext_limit;
    logic [6:0] limit;
    logic ack;
    logic [31:0] rdat;
  } psq_regs_t;

  psq_regs_t st;
  psq_regs_t next_st;

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // rotary steps of 11 A; positions past the last one hold the top step
  function automatic logic [6:0] rotary_amps(input logic [3:0] pos);
    logic [3:0] p;
    logic [10:0] prod;
    p = (pos > ROT_MAX_POS) ? ROT_MAX_POS : pos;
    prod = {7'h00, p} * {4'h0, ROT_STEP_A};
    return prod[6:0];
  endfunction : rotary_amps

  // controller values above the ceiling saturate instead of wrapping
  function automatic logic [6:0] clamp_amps(input logic [6:0] amps);
    return (amps > LIMIT_MAX_A) ? LIMIT_MAX_A : amps;
  endfunction : clamp_amps

  logic wb_req;
  logic wr_ctrl;
  logic on_req;
  logic off_req;
  logic ack_req;
  logic active;
  logic short_fail;
  logic cap_fail;
  logic oc_trip;
  logic severe_trip;
  logic fault_now;

  // bus strobe and request decode
  assign wb_req = I_WB.cyc & I_WB.stb & ~st.ack;
  assign wr_ctrl = wb_req & I_WB.we & I_WB.sel[0] & (I_WB.adr == REG_CTRL);
  // either source starts or stops the switch the same way
  assign on_req = (I_BTN_ON & ~st.on_prev) | (wr_ctrl & I_WB.dat[CTRL_ENABLE]);
  assign off_req = (I_BTN_OFF & ~st.off_prev) | (wr_ctrl & I_WB.dat[CTRL_DISABLE]);
  assign ack_req = off_req | (wr_ctrl & I_WB.dat[CTRL_FAULT_ACK]);

  // fault detection; the checks only look at the comparators at their instant
  assign active = (st.state == S_STAGE1) | (st.state == S_STAGE2) |
                  (st.state == S_SWITCHING) | (st.state == S_ON);
  assign short_fail = (st.state == S_STAGE1) & (st.timer == SHORT_AT) &
                      ~I_VOUT_ABOVE_10PCT;
  assign cap_fail = (st.state == S_STAGE2) & (st.timer == CAP_AT) &
                    ~I_VOUT_ABOVE_85PCT;
  assign oc_trip = active & I_OVER_LIMIT & (st.oc_cnt == OC_AT);
  assign severe_trip = active & I_OVER_160A;
  assign fault_now = short_fail | cap_fail | oc_trip | severe_trip;

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ready = 1'b1;
    next_st.on_prev = I_BTN_ON;
    next_st.off_prev = I_BTN_OFF;
    next_st.ack = wb_req;

    // register access; unmapped offsets answer with zero
    if (wb_req) begin
      next_st.rdat = 32'h0000_0000;
      if (!I_WB.we) begin
        case (I_WB.adr)
          REG_LIMIT: begin
            next_st.rdat[6:0] = st.ext_limit;
          end
          REG_STATUS: begin
            next_st.rdat[ST_PRECHARGE] = O_PRECHARGE_SWITCH;
            next_st.rdat[ST_MAIN_ON] = O_MAIN_PATH_ON;
            next_st.rdat[ST_SHORT] = st.faults.short_f;
            next_st.rdat[ST_CAP] = st.faults.cap_f;
            next_st.rdat[ST_OC] = st.faults.oc_f;
            next_st.rdat[ST_SEVERE] = st.faults.severe_f;
            next_st.rdat[ST_LIMIT_SRC] = I_LIMIT_SOURCE_SELECT;
            next_st.rdat[ST_LIMIT_LSB +: 7] = st.limit;
            next_st.rdat[ST_STATE_LSB +: 6] = st.state;
          end
          default: begin
            next_st.rdat = 32'h0000_0000;
          end
        endcase
      end else if (I_WB.sel[0] && I_WB.adr == REG_LIMIT) begin
        next_st.ext_limit = clamp_amps(I_WB.dat[6:0]);
      end
    end

    // selected limit goes out to the threshold converter
    next_st.limit = I_LIMIT_SOURCE_SELECT ? st.ext_limit : rotary_amps(I_ROTARY);

    // overcurrent must persist; any gap restarts the filter
    if (active && I_OVER_LIMIT) begin
      if (st.oc_cnt != OC_AT) begin
        next_st.oc_cnt = st.oc_cnt + OC_W'(1);
      end
    end else begin
      next_st.oc_cnt = '0;
    end

    // sequence
    case (st.state)
      S_IDLE: begin
        next_st.timer = '0;
        if (on_req) begin
          next_st.state = S_STAGE1;
        end
      end
      S_STAGE1: begin
        next_st.timer = st.timer + TIMER_W'(1);
        if (st.timer == SHORT_AT && I_VOUT_ABOVE_10PCT) begin
          next_st.state = S_STAGE2;
        end
      end
      S_STAGE2: begin
        next_st.timer = st.timer + TIMER_W'(1);
        if (st.timer == CAP_AT && I_VOUT_ABOVE_85PCT) begin
          next_st.state = S_SWITCHING;
          next_st.timer = '0;
        end
      end
      S_SWITCHING: begin
        next_st.timer = st.timer + TIMER_W'(1);
        if (st.timer == SETTLE_AT) begin
          next_st.state = S_ON;
        end
      end
      S_ON: begin
        next_st.timer = '0;
      end
      S_FAULT: begin
        // enable stays ignored here until an acknowledge arrives
        next_st.timer = '0;
        if (ack_req) begin
          next_st.state = S_IDLE;
          next_st.faults = '0;
        end
      end
      default: begin
        next_st.state = S_IDLE;
        next_st.timer = '0;
      end
    endcase

    // faults outrank a disable in the same cycle so none is lost
    if (fault_now) begin
      next_st.state = S_FAULT;
      next_st.timer = '0;
    end else if (off_req && active) begin
      next_st.state = S_IDLE;
      next_st.timer = '0;
    end

    // latch the cause; a set wins over an acknowledge
    if (short_fail) begin
      next_st.faults.short_f = 1'b1;
    end
    if (cap_fail) begin
      next_st.faults.cap_f = 1'b1;
    end
    if (oc_trip) begin
      next_st.faults.oc_f = 1'b1;
    end
    if (severe_trip) begin
      next_st.faults.severe_f = 1'b1;
    end
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st.state <= S_IDLE;
      st.timer <= '0;
      st.oc_cnt <= '0;
      st.faults <= '0;
      st.on_prev <= 1'b1;
      st.off_prev <= 1'b1;
      st.ready <= 1'b0;
      st.ext_limit <= LIMIT_RESET;
      st.limit <= LIMIT_RESET;
      st.ack <= 1'b0;
      st.rdat <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  // precharge only drives input to output; it opens in the cycle the gate is driven
  assign O_PRECHARGE_SWITCH = (st.state == S_STAGE1) | (st.state == S_STAGE2);
  assign O_PRECHARGE_INDICATOR = O_PRECHARGE_SWITCH;
  assign O_GATE_ON = (st.state == S_SWITCHING) | (st.state == S_ON);
  assign O_MAIN_PATH_ON = (st.state == S_ON);
  assign O_ON_INDICATOR = O_GATE_ON;
  assign O_READY_INDICATOR = st.ready;
  assign O_SHORT_INDICATOR = st.faults.short_f;
  assign O_CAPACITANCE_FAULT_INDICATOR = st.faults.cap_f;
  // the severe trip has no lamp of its own, so it shares the overcurrent one
  assign O_OVERCURRENT_INDICATOR = st.faults.oc_f | st.faults.severe_f;
  assign O_LIMIT_AMPS = st.limit;
  // one driver for the whole response word keeps the struct net single-sourced
  assign O_WB = '{ack: st.ack, dat: st.rdat};

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESET_N);

  a_short_abort: assert property (
    short_fail |=> (st.state == S_FAULT) && O_SHORT_INDICATOR && !O_PRECHARGE_SWITCH)
    else $error("short check failure did not abort");

  a_stage_advance: assert property (
    (st.state == S_STAGE1) && (st.timer == SHORT_AT) && I_VOUT_ABOVE_10PCT && !fault_now
    && !off_req |=> (st.state == S_STAGE2) && O_PRECHARGE_SWITCH)
    else $error("passed short check did not continue");

  a_cap_abort: assert property (
    cap_fail |=> O_CAPACITANCE_FAULT_INDICATOR && !O_GATE_ON)
    else $error("capacitance check failure did not abort");

  a_gate_order: assert property (
    $rose(O_GATE_ON) |-> $past(st.state == S_STAGE2) && $past(st.timer == CAP_AT)
    && $past(I_VOUT_ABOVE_85PCT))
    else $error("gate driven without both stages passing");

  a_main_delay: assert property (
    $rose(O_MAIN_PATH_ON) |-> $past(st.state == S_SWITCHING) && $past(st.timer == SETTLE_AT))
    else $error("main path flag not tied to gate settle");

  a_fault_block: assert property (
    (st.state == S_FAULT) && !ack_req |=> (st.state == S_FAULT) && !O_PRECHARGE_SWITCH)
    else $error("latched fault let the switch restart");

  a_oc_filter: assert property (
    $rose(st.faults.oc_f) |-> $past(st.oc_cnt) == OC_AT && $past(I_OVER_LIMIT))
    else $error("overcurrent tripped before filter time");

  a_severe_trip: assert property (
    severe_trip |=> st.faults.severe_f && !O_GATE_ON && !O_PRECHARGE_SWITCH)
    else $error("severe overcurrent did not open switches");

  a_limit_select: assert property (
    I_LIMIT_SOURCE_SELECT && $stable(st.ext_limit) |=> O_LIMIT_AMPS == $past(st.ext_limit))
    else $error("programmed limit not selected");

  a_disable_stop: assert property (
    active && off_req && !fault_now |=> (st.state == S_IDLE) && !O_GATE_ON && (st.timer == '0))
    else $error("disable did not open switches");

  a_bus_ack: assert property (
    I_WB.cyc && I_WB.stb && !O_WB.ack |=> O_WB.ack ##1 !O_WB.ack)
    else $error("bus ack not single cycle");

  a_enable_start: assert property (
    (st.state == S_IDLE) && on_req |=> O_PRECHARGE_SWITCH && O_PRECHARGE_INDICATOR
    && (st.timer == '0))
    else $error("enable did not close precharge switch");

  a_ready_lamp: assert property (
    $past(I_RESET_N) |-> O_READY_INDICATOR)
    else $error("ready lamp dark while running");

  a_on_lamp: assert property (
    O_MAIN_PATH_ON |-> O_ON_INDICATOR && O_GATE_ON && !O_PRECHARGE_SWITCH)
    else $error("on lamp dark while main path on");

  a_precharge_open: assert property (
    O_GATE_ON || (st.state == S_FAULT) |-> !O_PRECHARGE_SWITCH && !O_PRECHARGE_INDICATOR)
    else $error("precharge path left closed");

  a_fault_clear: assert property (
    (st.state == S_FAULT) && ack_req |=> (st.state == S_IDLE) && (st.faults == '0))
    else $error("acknowledge did not clear fault");

  a_oc_lamp: assert property (
    $rose(st.faults.oc_f) |-> O_OVERCURRENT_INDICATOR && (st.state == S_FAULT) && !O_GATE_ON)
    else $error("overcurrent fault did not open switches");

endmodule : psq_sequencer

//--- psq_pkg.sv
// Contract
// - enable closes precharge switch, lights precharge indicator
// - at 25 ms, below 10 % aborts as short
// - first check passes, precharge continues to stage two
// - at capacitance check, below 85 % aborts as capacitance
// - capacitance check instant is a settable constant
// - main switches only after both stages pass
// - main path on flag 1 us after gate command
// - on indicator while main switches conduct
// - ready indicator while control logic operates
// - adjustable overcurrent latches fault, lights indicator
// - any fault opens all switches, lights its indicator
// - latched fault blocks enable until acknowledged
// - buttons and controller requests treated alike
// - rotary positions map to 0..99 A, 11 A steps
// - precharge path only for input to output
// - adjustable overcurrent trips after more than 300 us
// - fixed 160 A trips at once, severe fault
package psq_pkg;

  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1_000;
  localparam int unsigned T_SHORT_CHECK_MS = 25;
  localparam int unsigned T_CAP_CHECK_MS = 300;
  localparam int unsigned T_OC_FILTER_US = 300;
  localparam int unsigned T_GATE_SETTLE_US = 1;
  localparam int TIMER_W = 26;
  localparam int OC_W = 16;

  // ----------------------------------------------------------
  // current limit
  // ----------------------------------------------------------
  localparam logic [6:0] LIMIT_MAX_A = 7'h63;
  localparam logic [3:0] ROT_MAX_POS = 4'h9;
  localparam logic [6:0] ROT_STEP_A = 7'h0B;
  localparam logic [6:0] LIMIT_RESET = 7'h00;

  // ----------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LIMIT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_DISABLE = 1;
  localparam int CTRL_FAULT_ACK = 2;
  localparam int ST_PRECHARGE = 0;
  localparam int ST_MAIN_ON = 1;
  localparam int ST_SHORT = 2;
  localparam int ST_CAP = 3;
  localparam int ST_OC = 4;
  localparam int ST_SEVERE = 5;
  localparam int ST_LIMIT_SRC = 6;
  localparam int ST_LIMIT_LSB = 8;
  localparam int ST_STATE_LSB = 16;

  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_STAGE1 = 6'h02,
    S_STAGE2 = 6'h04,
    S_SWITCHING = 6'h08,
    S_ON = 6'h10,
    S_FAULT = 6'h20
  } psq_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } psq_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } psq_wb_rsp_t;

  typedef struct packed {
    logic short_f;
    logic cap_f;
    logic oc_f;
    logic severe_f;
  } psq_faults_t;

endpackage : psq_pkg

//--- psq_partner.sv
`timescale 1ns/10ps
module psq_partner #(
  parameter int unsigned S = 20
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // power stage that feeds the load
  input wire logic i_precharge,
  input wire logic i_gate,
  // load kind: 0 healthy, 1 shorted, 2 too much capacitance
  input wire logic [1:0] i_load,
  // comparator outputs
  output logic o_above_10,
  output logic o_above_85
);
  int unsigned cnt;
  // ----------------------------------------------------------
  // output voltage model
  // ----------------------------------------------------------
  // charge only flows forward through the resistor path; isolated load bleeds down
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt <= 0;
    end else if (i_precharge) begin
      cnt <= cnt + 1;
    end else if (!i_gate) begin
      cnt <= 0;
    end
  end
  // a shorted load never lifts, a big capacitor stalls below the upper threshold
  assign o_above_10 = (i_load != 2'h1) && (i_gate || cnt >= 2);
  assign o_above_85 = (i_load == 2'h0) && (i_gate || cnt >= S + 5);
endmodule : psq_partner

//--- psq_sequencer_bench.sv
`timescale 1ns/10ps
module psq_sequencer_bench;
  import psq_pkg::*;
  localparam int S = 20;
  localparam int C = 60;
  localparam int OC = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  psq_wb_req_t wb = '0;
  psq_wb_rsp_t wb_rsp;
  logic btn_on = 1'b0;
  logic btn_off = 1'b0;
  logic lsel = 1'b0;
  logic ovl = 1'b0;
  logic o160 = 1'b0;
  logic [3:0] rot = 4'h0;
  logic [1:0] load = 2'h0;
  logic a10, a85, pre, gate, mainp, rdy, pre_ind, on_ind, sh_ind, cap_ind, oc_ind;
  logic [6:0] lim;
  logic [31:0] q;
  int bad_count = 0;
  int n_tests = 0;
  int n;

  // ----------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------
  always #10 clk = ~clk;
  psq_sequencer #(.SHORT_CHECK_CYC(S), .CAP_CHECK_CYC(C), .OC_FILTER_CYC(OC))
    psq_sequencer_inst (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_WB(wb), .O_WB(wb_rsp),
    .I_BTN_ON(btn_on), .I_BTN_OFF(btn_off), .I_ROTARY(rot), .I_LIMIT_SOURCE_SELECT(lsel),
    .I_VOUT_ABOVE_10PCT(a10), .I_VOUT_ABOVE_85PCT(a85), .I_OVER_LIMIT(ovl),
    .I_OVER_160A(o160), .O_PRECHARGE_SWITCH(pre), .O_GATE_ON(gate), .O_MAIN_PATH_ON(mainp),
    .O_LIMIT_AMPS(lim), .O_READY_INDICATOR(rdy), .O_PRECHARGE_INDICATOR(pre_ind),
    .O_ON_INDICATOR(on_ind), .O_SHORT_INDICATOR(sh_ind),
    .O_CAPACITANCE_FAULT_INDICATOR(cap_ind), .O_OVERCURRENT_INDICATOR(oc_ind));
  psq_partner #(.S(S)) psq_partner_inst (.i_clk(clk), .i_reset_n(rst_n), .i_precharge(pre),
    .i_gate(gate), .i_load(load), .o_above_10(a10), .o_above_85(a85));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; outputs are read at the edge, so they show the prior cycle
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    wb <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    q = wb_rsp.dat;
    wb <= '0;
    @(posedge clk);
    if (n >= 50) begin
      bad_count++;
      end_sim;
    end
  endtask : bus

  function automatic logic pick(input int k);
    case (k)
      0: return gate;
      1: return mainp;
      2: return sh_ind;
      3: return cap_ind;
      default: return oc_ind;
    endcase
  endfunction : pick

  // bounded wait; a hang counts as a mismatch and closes the run
  task wait_hi(input int k);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pick(k) !== 1'b1 && n < 400);
    if (n >= 400) begin
      bad_count++;
      end_sim;
    end
  endtask : wait_hi

  task pulse_off;
    btn_off <= 1'b1;
    @(posedge clk);
    btn_off <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_off

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    chk(rdy, 1'b0);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(rdy, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[21:16], 6'h01);
    bus(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, REG_LIMIT, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 10; i++) begin
      rot <= i[3:0];
      repeat (3) @(posedge clk);
      chk(lim, i * 11);
    end
    bus(1'b1, REG_LIMIT, 32'h2A);
    lsel <= 1'b1;
    repeat (3) @(posedge clk);
    chk(lim, 7'h2A);
    bus(1'b1, REG_LIMIT, 32'h7F);
    bus(1'b0, REG_LIMIT, 32'h0);
    chk(q[6:0], 7'h63);
    lsel <= 1'b0;
    $display("limit test done");
    // healthy load via the on button
    btn_on <= 1'b1;
    repeat (2) @(posedge clk);
    chk(pre_ind, 1'b1);
    chk(gate, 1'b0);
    wait_hi(0);
    chk(n, C);
    chk(pre_ind, 1'b0);
    chk(on_ind, 1'b1);
    btn_on <= 1'b0;
    wait_hi(1);
    chk(n, T_GATE_SETTLE_US * CYC_PER_US);
    bus(1'b0, REG_STATUS, 32'h0);
    chk({q[21:16], q[1:0]}, 8'h42);
    // a burst one cycle too short must not trip the filter
    ovl <= 1'b1;
    repeat (OC) @(posedge clk);
    ovl <= 1'b0;
    repeat (2) @(posedge clk);
    chk(oc_ind, 1'b0);
    ovl <= 1'b1;
    wait_hi(4);
    chk(n, OC + 2);
    chk({gate, mainp, pre}, 3'h0);
    ovl <= 1'b0;
    bus(1'b1, REG_CTRL, 32'h4);
    bus(1'b0, REG_STATUS, 32'h0);
    chk({q[21:16], q[4]}, 7'h02);
    $display("on and overcurrent test done");
    // controller enable, then the fixed limit trips at once
    bus(1'b1, REG_CTRL, 32'h1);
    wait_hi(0);
    o160 <= 1'b1;
    wait_hi(4);
    chk(n, 2);
    chk(gate, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[5:4], 2'h2);
    o160 <= 1'b0;
    pulse_off();
    chk(oc_ind, 1'b0);
    $display("severe test done");
    // shorted load, enable ignored while the fault stands
    load <= 2'h1;
    btn_on <= 1'b1;
    wait_hi(2);
    chk(n, S + 2);
    chk({pre, gate}, 2'h0);
    btn_on <= 1'b0;
    @(posedge clk);
    btn_on <= 1'b1;
    repeat (3) @(posedge clk);
    chk({pre, sh_ind}, 2'h1);
    btn_on <= 1'b0;
    pulse_off();
    chk(sh_ind, 1'b0);
    $display("short test done");
    // oversized capacitor, enabled and acknowledged over the bus
    load <= 2'h2;
    bus(1'b1, REG_CTRL, 32'h1);
    chk(pre, 1'b1);
    wait_hi(3);
    chk({pre, gate}, 2'h0);
    bus(1'b1, REG_CTRL, 32'h2);
    chk(cap_ind, 1'b0);
    // disable in mid precharge opens the path
    load <= 2'h0;
    bus(1'b1, REG_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    bus(1'b1, REG_CTRL, 32'h2);
    chk({pre, gate}, 2'h0);
    $display("capacitance and disable test done");
    end_sim();
  end
endmodule : psq_sequencer_bench
